// ==== rtl/can_status_led_sequencer.sv ====
// front-panel indicator sequencer with apb control and status
//
// Notes on behaviour
// - the power light comes on first, when peripheral start-up begins after reset.
// - the green run light starts blinking once the CAN controller is initialised.
// - with Ethernet link up the link light is lit and the rate light shows 10 or 100 Mbps.
// - while the IP address is acquired the rate light blinks and Ethernet traffic is held off.
// - both CAN colours dark means a master connection with nothing else to report.
// - bit-rate detection overrides every state and error pattern with flicker.
// - pre-operational blinks green with 200 ms on and 200 ms off.
// - operational holds green steadily on.
// - stopped repeats one green flash then a 1 s dark pause.
// - warning limit repeats one red flash then a 1 s dark pause.
// - a node guarding event repeats two red flashes then a 1 s dark pause.
// - a sync error in operational repeats three red flashes then 1 s dark, green on.
// - bus-off keeps red constantly lit.
// - detection or layer setting flickers red and green alternately in 50 ms steps.
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "led_seq_defines.svh"
module can_status_led_sequencer #(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [31:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire led_seq_pkg::can_flags_t can_flags,
    input  wire led_seq_pkg::eth_flags_t eth_flags,
    output led_seq_pkg::leds_t           leds,
    output logic                         eth_comm_en
);
    localparam logic [2:0] BLINK_LAST = 3'(`BLINK_TICKS - 1);

    typedef enum logic [1:0] {SEQ_OFF, SEQ_POWER, SEQ_READY} seq_t;

    ////////////////////////////////////////////////////////////////////////
    // shared tick and flash pattern engines
    logic                    tick;
    logic                    red_flash;
    logic                    green_flash;
    logic [1:0]              red_count;
    led_seq_pkg::err_class_t err_class;

    tick_gen #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    flash_seq u_red (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick),
        .count   (red_count),
        .led     (red_flash)
    );

    flash_seq u_green (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick),
        .count   (`FLASH_ONE),
        .led     (green_flash)
    );

    ////////////////////////////////////////////////////////////////////////
    // error classification
    always_comb begin
        if (can_flags.bus_off) begin
            err_class = led_seq_pkg::ERR_BUSOFF;
        end else if (can_flags.sync_err && can_flags.node == led_seq_pkg::NODE_OPER) begin
            err_class = led_seq_pkg::ERR_SYNC;
        end else if (can_flags.guard) begin
            err_class = led_seq_pkg::ERR_GUARD;
        end else if (can_flags.warn) begin
            err_class = led_seq_pkg::ERR_WARN;
        end else begin
            err_class = led_seq_pkg::ERR_NONE;
        end
        unique case (err_class)
            led_seq_pkg::ERR_SYNC:  red_count = `FLASH_THREE;
            led_seq_pkg::ERR_GUARD: red_count = `FLASH_TWO;
            led_seq_pkg::ERR_WARN:  red_count = `FLASH_ONE;
            default:                red_count = `FLASH_NONE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // start-up sequence and blink phases
    seq_t       seq_q;
    seq_t       seq_d;
    logic [2:0] bcnt_q;
    logic [2:0] bcnt_d;
    logic       blink_q;
    logic       blink_d;
    logic       flick_q;
    logic       flick_d;

    always_comb begin
        seq_d   = seq_q;
        bcnt_d  = bcnt_q;
        blink_d = blink_q;
        flick_d = flick_q;
        unique case (seq_q)
            SEQ_OFF:   seq_d = SEQ_POWER;
            SEQ_POWER: seq_d = can_flags.ctrl_ready ? SEQ_READY : SEQ_POWER;
            SEQ_READY: seq_d = SEQ_READY;
        endcase
        if (tick) begin
            flick_d = !flick_q;
            bcnt_d  = (bcnt_q == BLINK_LAST) ? 3'h0 : bcnt_q + 3'h1;
            blink_d = (bcnt_q == BLINK_LAST) ? !blink_q : blink_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_q   <= SEQ_OFF;
            bcnt_q  <= '0;
            blink_q <= 1'b0;
            flick_q <= 1'b0;
        end else begin
            seq_q   <= seq_d;
            bcnt_q  <= bcnt_d;
            blink_q <= blink_d;
            flick_q <= flick_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // indicator outputs
    logic [1:0]         ctrl_q;
    logic [1:0]         ctrl_d;
    led_seq_pkg::leds_t leds_q;
    led_seq_pkg::leds_t leds_d;
    logic               comm_q;
    logic               comm_d;
    logic               live;

    always_comb begin
        live   = (seq_q == SEQ_READY) && ctrl_q[`CTRL_EN_BIT];
        leds_d = '0;
        leds_d.power = (seq_q != SEQ_OFF);
        if (live) begin
            if (can_flags.autobaud) begin
                leds_d.can_red   = flick_q;
                leds_d.can_green = !flick_q;
            end else begin
                leds_d.can_red = (err_class == led_seq_pkg::ERR_BUSOFF) || red_flash;
                unique case (can_flags.node)
                    led_seq_pkg::NODE_PREOP:   leds_d.can_green = blink_q;
                    led_seq_pkg::NODE_OPER:    leds_d.can_green = 1'b1;
                    led_seq_pkg::NODE_STOPPED: leds_d.can_green = green_flash;
                    led_seq_pkg::NODE_IDLE:    leds_d.can_green = 1'b0;
                endcase
            end
            leds_d.link = eth_flags.link;
            leds_d.rate = eth_flags.link &&
                          (eth_flags.ip_pending ? blink_q : eth_flags.rate_100);
        end
        // lamp test overrides everything so a dead lamp is easy to spot
        if (ctrl_q[`CTRL_TEST_BIT]) begin
            leds_d = '1;
        end
        comm_d = eth_flags.link && !eth_flags.ip_pending;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            leds_q <= '0;
            comm_q <= 1'b0;
        end else begin
            leds_q <= leds_d;
            comm_q <= comm_d;
        end
    end

    assign leds        = leds_q;
    assign eth_comm_en = comm_q;

    ////////////////////////////////////////////////////////////////////////
    // apb slave, one wait state per transfer
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        pready_q;
    logic        pready_d;
    logic        pslverr_q;
    logic        pslverr_d;
    logic        hit_ctrl;
    logic        hit_stat;

    always_comb begin
        hit_ctrl  = (paddr == `REG_CTRL);
        hit_stat  = (paddr == `REG_STAT);
        pready_d  = psel && penable && !pready_q;
        pslverr_d = pready_d && !(hit_ctrl || hit_stat);
        prdata_d  = prdata_q;
        ctrl_d    = ctrl_q;
        if (pready_d && !pwrite) begin
            prdata_d = '0;
            if (hit_ctrl) begin
                prdata_d[1:0] = ctrl_q;
            end else if (hit_stat) begin
                prdata_d[9:0] = {3'(err_class), leds_q, seq_q};
            end
        end
        if (psel && penable && pready_q && pwrite && hit_ctrl) begin
            ctrl_d = pwdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= '0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            ctrl_q    <= `CTRL_RESET;
        end else begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            ctrl_q    <= ctrl_d;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic norm;
    assign norm = live && !ctrl_q[`CTRL_TEST_BIT] && !can_flags.autobaud;

    AST_POWER_FIRST: assert property (!leds_q.power |-> leds_q == '0)
        else $error("indicator lit before power light");
    AST_RUN_AFTER_INIT: assert property ((seq_q != SEQ_READY) && !ctrl_q[`CTRL_TEST_BIT]
        |=> !leds_q.can_green) else $error("green lit before controller ready");
    AST_LINK_LIGHT: assert property (live && !ctrl_q[`CTRL_TEST_BIT]
        |=> leds_q.link == $past(eth_flags.link)) else $error("link light wrong");
    AST_COMM_HOLD: assert property (eth_flags.ip_pending |=> !eth_comm_en)
        else $error("traffic enabled during address acquisition");
    AST_BUSOFF_RED: assert property (norm && can_flags.bus_off |=> leds_q.can_red)
        else $error("red not lit in bus-off");
    AST_OPER_GREEN: assert property (norm && can_flags.node == led_seq_pkg::NODE_OPER
        |=> leds_q.can_green) else $error("green not steady in operational");
    AST_FLICKER_ALT: assert property (live && !ctrl_q[`CTRL_TEST_BIT]
        && can_flags.autobaud |=> leds_q.can_red != leds_q.can_green)
        else $error("flicker not alternate");
    AST_FLICKER_WINS: assert property (live && !ctrl_q[`CTRL_TEST_BIT]
        && can_flags.autobaud |=> leds_q.can_red == $past(flick_q))
        else $error("flicker did not override the error pattern");
    AST_SYNC_OPER: assert property (err_class == led_seq_pkg::ERR_SYNC
        |-> can_flags.node == led_seq_pkg::NODE_OPER) else $error("sync class off state");
    AST_PRECEDENCE: assert property (can_flags.bus_off
        |-> err_class == led_seq_pkg::ERR_BUSOFF) else $error("bus-off lost precedence");
    AST_APB_WAIT: assert property (psel && !penable ##1 psel && penable |=> pready_q)
        else $error("apb answer not after one wait state");

    COV_FLICKER: cover property (live && can_flags.autobaud ##1 leds_q.can_red);
    COV_TRIPLE: cover property (err_class == led_seq_pkg::ERR_SYNC ##1 red_flash);
    COV_CTRL_WR: cover property (psel && penable && pready_q && pwrite && hit_ctrl);
    COV_BUSOFF: cover property (norm && can_flags.bus_off ##1 leds_q.can_red);
endmodule

// ==== rtl/led_seq_defines.svh ====
// timing, register map and field constants of the indicator sequencer
`ifndef LED_SEQ_DEFINES_SVH
`define LED_SEQ_DEFINES_SVH

`define CLK_MHZ         100
`define TICK_MS         50
`define FLASH_MS        200
`define PAUSE_MS        1000
`define TICK_CYCLES     (`CLK_MHZ * 1000 * `TICK_MS)
`define FLASH_TICKS     (`FLASH_MS / `TICK_MS)
`define PAUSE_TICKS     (`PAUSE_MS / `TICK_MS)
`define BLINK_TICKS     (`FLASH_MS / `TICK_MS)

`define REG_CTRL        32'h0000_0000
`define REG_STAT        32'h0000_0004
`define CTRL_EN_BIT     0
`define CTRL_TEST_BIT   1
`define CTRL_RESET      2'h1
`define FLASH_NONE      2'h0
`define FLASH_ONE       2'h1
`define FLASH_TWO       2'h2
`define FLASH_THREE     2'h3

`endif

// ==== rtl/led_seq_pkg.sv ====
// types shared by the indicator sequencer files
package led_seq_pkg;

    typedef enum logic [1:0] {NODE_IDLE, NODE_PREOP, NODE_OPER, NODE_STOPPED} node_state_t;

    typedef enum logic [2:0] {ERR_NONE, ERR_WARN, ERR_GUARD, ERR_SYNC, ERR_BUSOFF} err_class_t;

    typedef struct packed {
        logic        ctrl_ready;
        logic        autobaud;
        logic        bus_off;
        logic        warn;
        logic        guard;
        logic        sync_err;
        node_state_t node;
    } can_flags_t;

    typedef struct packed {
        logic link;
        logic rate_100;
        logic ip_pending;
    } eth_flags_t;

    typedef struct packed {
        logic power;
        logic can_green;
        logic can_red;
        logic link;
        logic rate;
    } leds_t;

endpackage

// ==== rtl/tick_gen.sv ====
// prescaler giving one-cycle pattern tick
`timescale 1ns/1ps
`include "led_seq_defines.svh"
module tick_gen #(
    parameter int unsigned CYCLES = `TICK_CYCLES
) (
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      tick
);
    localparam int unsigned W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         tick_q;
    logic         tick_d;

    always_comb begin
        tick_d = (cnt_q == LAST);
        cnt_d  = tick_d ? '0 : cnt_q + W'(1);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

    AST_TICK_SINGLE: assert property (@(posedge pclk) disable iff (!presetn)
        (CYCLES > 1) && tick_q |=> !tick_q) else $error("tick lasted two cycles");
endmodule

// ==== rtl/flash_seq.sv ====
// repeating group of n flashes followed by a long dark pause
`timescale 1ns/1ps
`include "led_seq_defines.svh"
module flash_seq #(
    parameter int unsigned FLASH_T = `FLASH_TICKS,
    parameter int unsigned PAUSE_T = `PAUSE_TICKS
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       tick,
    input  wire logic [1:0] count,
    output logic            led
);
    localparam logic [4:0] F_LAST = 5'(FLASH_T - 1);
    localparam logic [4:0] P_LAST = 5'(PAUSE_T - 1);

    logic [2:0] slot_q;
    logic [2:0] slot_d;
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic [1:0] n_q;
    logic [1:0] n_d;
    logic       led_q;
    logic       led_d;
    logic       last;

    // count is latched only at group start so a change never cuts a group
    always_comb begin
        last   = (slot_q == 3'({n_q, 1'b0} - 3'h1));
        slot_d = slot_q;
        cnt_d  = cnt_q;
        n_d    = n_q;
        if (tick) begin
            if (n_q == `FLASH_NONE) begin
                n_d    = count;
                slot_d = '0;
                cnt_d  = '0;
            end else if (cnt_q == (last ? P_LAST : F_LAST)) begin
                cnt_d  = '0;
                slot_d = last ? 3'h0 : slot_q + 3'h1;
                n_d    = last ? count : n_q;
            end else begin
                cnt_d  = cnt_q + 5'h1;
            end
        end
        led_d = (n_d != `FLASH_NONE) && !slot_d[0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_q <= '0;
            cnt_q  <= '0;
            n_q    <= `FLASH_NONE;
            led_q  <= 1'b0;
        end else begin
            slot_q <= slot_d;
            cnt_q  <= cnt_d;
            n_q    <= n_d;
            led_q  <= led_d;
        end
    end

    assign led = led_q;

    AST_FLASH_PAUSE_DARK: assert property (@(posedge pclk) disable iff (!presetn)
        slot_q[0] |-> !led_q) else $error("flash lit in a dark slot");
endmodule

// ==== bench/led_panel_watch.sv ====
// operator-side model of the front panel: counts lit cycles and flash starts
`timescale 1ns/1ps
module led_panel_watch (
    input  wire logic               pclk,
    input  wire logic               clr,
    input  wire led_seq_pkg::leds_t leds,
    output logic [15:0]             green_on,
    output logic [15:0]             red_on,
    output logic [15:0]             rate_on,
    output logic [15:0]             red_edges,
    output logic [15:0]             green_edges,
    output logic [15:0]             same_cnt
);
    led_seq_pkg::leds_t prev;

    ////////////////////////////////////////////////////////////////////////////
    // counts over a window are phase independent when it spans whole periods
    always_ff @(posedge pclk) begin
        if (clr) begin
            green_on    <= 16'h0000;
            red_on      <= 16'h0000;
            rate_on     <= 16'h0000;
            red_edges   <= 16'h0000;
            green_edges <= 16'h0000;
            same_cnt    <= 16'h0000;
        end else begin
            green_on    <= green_on + 16'(leds.can_green);
            red_on      <= red_on + 16'(leds.can_red);
            rate_on     <= rate_on + 16'(leds.rate);
            red_edges   <= red_edges + 16'(leds.can_red & ~prev.can_red);
            green_edges <= green_edges + 16'(leds.can_green & ~prev.can_green);
            same_cnt    <= same_cnt + 16'(leds.can_red == leds.can_green);
        end
        prev <= leds;
    end
endmodule

// ==== bench/tb_top.sv ====
// self-checking bench for the indicator sequencer
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin bad_count++; \
    $display("unexpected %s: expected %0h seen %0h", nm, ex, got); end end
module tb_top;
    logic                   pclk;
    logic                   presetn;
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [31:0]            paddr;
    logic [31:0]            pwdata;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    led_seq_pkg::can_flags_t can_flags;
    led_seq_pkg::eth_flags_t eth_flags;
    led_seq_pkg::leds_t      leds;
    logic                   eth_comm_en;
    logic                   clr;
    logic [15:0]            g_on, r_on, b_on, r_edg, g_edg, same;
    logic [31:0]            rd;
    logic                   err;
    int                     bad_count;
    int                     tests_run;
    // small tick so flash = 16 cycles, pause = 80 cycles
    localparam int unsigned TICK = 4;
    // per entry: {busoff,sync,guard,warn}, node, window, red starts, red lit, green lit, class
    logic [3:0]  e_flags [5] = '{4'h1, 4'h3, 4'h7, 4'hf, 4'h5};
    logic [1:0]  e_node  [5] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h1};
    int          e_win   [5] = '{480, 512, 480, 480, 480};
    logic [15:0] e_edg   [5] = '{16'h0005, 16'h0008, 16'h0009, 16'h0000, 16'h0005};
    logic [15:0] e_ron   [5] = '{16'h0050, 16'h0080, 16'h0090, 16'h01e0, 16'h0050};
    logic [15:0] e_gon   [5] = '{16'h01e0, 16'h0200, 16'h01e0, 16'h01e0, 16'h00f0};
    logic [2:0]  e_cls   [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h1};

    can_status_led_sequencer #(.TICK_CYCLES(TICK)) can_status_led_sequencer_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .can_flags(can_flags), .eth_flags(eth_flags), .leds(leds), .eth_comm_en(eth_comm_en));

    led_panel_watch led_panel_watch_inst (
        .pclk(pclk), .clr(clr), .leds(leds), .green_on(g_on), .red_on(r_on),
        .rate_on(b_on), .red_edges(r_edg), .green_edges(g_edg), .same_cnt(same));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #400_000;
        bad_count++;
        $display("unexpected watchdog expiry");
        end_sim();
    end

    // one apb transfer; the slave's wait states are not assumed
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
            $display("unexpected apb ready timeout");
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // clear the panel counters, then watch n cycles
    task automatic watch(input int n);
        @(posedge pclk);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic done(input string nm);
        $display("test %s finished", nm);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        bad_count = 0;
        tests_run = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, clr} = 4'h0;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
        can_flags = '0;
        eth_flags = 3'h6;
        repeat (16) @(posedge pclk);
        #1;
        `CHK("leds in reset", 5'h00, leds)
        @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        #1;
        // power first, link held back
        `CHK("leds power only", 5'h10, leds)
        apb(1'b0, 32'h0000_0000, 32'h0000_0000);
        `CHK("ctrl reset", 32'h0000_0001, rd)
        apb(1'b0, 32'h0000_0004, 32'h0000_0000);
        `CHK("stat seq", 32'h0000_0041, rd)
        done("startup");

        can_flags.ctrl_ready <= 1'b1;
        eth_flags <= 3'h0;
        watch(40);
        `CHK("idle dark", 16'h0000, g_on + r_on)
        @(posedge pclk);
        can_flags.node <= led_seq_pkg::NODE_PREOP;
        watch(40);
        watch(320);
        `CHK("preop green", 16'h00a0, g_on)
        `CHK("preop starts", 16'h000a, g_edg)
        @(posedge pclk);
        can_flags.node <= led_seq_pkg::NODE_STOPPED;
        watch(120);
        watch(480);
        `CHK("stopped green", 16'h0050, g_on)
        `CHK("stopped starts", 16'h0005, g_edg)
        @(posedge pclk);
        can_flags.node <= led_seq_pkg::NODE_OPER;
        watch(320);
        `CHK("oper green", 16'h0140, g_on)
        done("node states");

        @(posedge pclk);
        for (int i = 0; i < 5; i++) begin
            {can_flags.bus_off, can_flags.sync_err, can_flags.guard, can_flags.warn}
                <= e_flags[i];
            can_flags.node <= led_seq_pkg::node_state_t'(e_node[i]);
            watch(320);
            watch(e_win[i]);
            `CHK("red starts", e_edg[i], r_edg)
            `CHK("red lit", e_ron[i], r_on)
            `CHK("green beside error", e_gon[i], g_on)
            apb(1'b0, 32'h0000_0004, 32'h0000_0000);
            `CHK("stat class", e_cls[i], rd[9:7])
        end
        done("errors");

        can_flags.node <= led_seq_pkg::NODE_OPER;
        can_flags.bus_off <= 1'b1;
        can_flags.autobaud <= 1'b1;
        watch(16);
        watch(64);
        `CHK("flicker green", 16'h0020, g_on)
        `CHK("flicker red", 16'h0020, r_on)
        `CHK("flicker opposite", 16'h0000, same)
        @(posedge pclk);
        can_flags <= '{ctrl_ready: 1'b1, node: led_seq_pkg::NODE_OPER, default: 1'b0};
        done("flicker");

        eth_flags <= 3'h6;
        repeat (3) @(posedge pclk);
        #1;
        `CHK("link fast", 3'h7, {leds.link, leds.rate, eth_comm_en})
        @(posedge pclk);
        eth_flags <= 3'h4;
        repeat (3) @(posedge pclk);
        #1;
        `CHK("link slow", 3'h5, {leds.link, leds.rate, eth_comm_en})
        @(posedge pclk);
        eth_flags <= 3'h5;
        watch(40);
        watch(320);
        `CHK("ip blink", 16'h00a0, b_on)
        `CHK("ip hold off", 1'b0, eth_comm_en)
        @(posedge pclk);
        eth_flags <= 3'h2;
        repeat (3) @(posedge pclk);
        #1;
        `CHK("link down", 3'h0, {leds.link, leds.rate, eth_comm_en})
        done("ethernet");

        @(posedge pclk);
        eth_flags <= 3'h6;
        apb(1'b1, 32'h0000_0000, 32'h0000_0000);
        repeat (4) @(posedge pclk);
        #1;
        `CHK("disabled", 5'h10, leds)
        apb(1'b1, 32'h0000_0000, 32'h0000_0002);
        repeat (4) @(posedge pclk);
        #1;
        `CHK("lamp test", 5'h1f, leds)
        apb(1'b1, 32'h0000_0000, 32'h0000_0001);
        apb(1'b0, 32'h0000_0000, 32'h0000_0000);
        `CHK("ctrl back", 32'h0000_0001, rd)
        apb(1'b1, 32'h0000_0004, 32'h0000_0003);
        `CHK("stat write err", 1'b0, err)
        apb(1'b0, 32'h0000_0008, 32'h0000_0000);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0000_0000, rd)
        apb(1'b1, 32'h0000_0008, 32'h0000_0000);
        `CHK("unmapped write err", 1'b1, err)
        done("registers");
        end_sim();
    end
endmodule
